// ---- pkg/dccl_defines.svh ----
/*
  Constants of the compensating-filter coefficient loader: control addresses,
  page values, field positions and reset values.
  Assumes it is included by bare name before any use of the macros.
*/
`ifndef DCCL_DEFINES_SVH
`define DCCL_DEFINES_SVH

// ============================================================
// Control addresses
`define DCCL_ADDR_W          6
`define DCCL_DATA_W          16
`define DCCL_OFS_MODE        6'h00
`define DCCL_OFS_GAIN        6'h01
`define DCCL_OFS_PAGE        6'h21
`define DCCL_WIN_LAST        6'h1F

// ============================================================
// Page-select values
`define DCCL_PG_LO0          16'h0480
`define DCCL_PG_LO1          16'h04A0
`define DCCL_PG_HI0          16'h04C0
`define DCCL_PG_HI1          16'h04E0
`define DCCL_PG_CTRL         16'h0500

// ============================================================
// Coefficient memories
`define DCCL_COEF_W          18
`define DCCL_LO_W            2
`define DCCL_RAM_DEPTH       32
`define DCCL_RAM_AW          5

// ============================================================
// Mode register fields
`define DCCL_MODE_CDMA_BIT   15
`define DCCL_MODE_RDBK_BIT   14
`define DCCL_MODE_TAPS_MSB   4
`define DCCL_MODE_TAPS_LSB   0

// ============================================================
// Gain register fields
`define DCCL_GAIN_SHP_MSB    15
`define DCCL_GAIN_SHP_LSB    12
`define DCCL_GAIN_CFIR_BIT   8

// ============================================================
// Reset values
`define DCCL_RST_PAGE        16'h0000
`define DCCL_RST_MODE        16'h0000
`define DCCL_RST_GAIN        16'h0000

`endif

// ---- pkg/dccl_pkg.sv ----
/*
  Types of the compensating-filter coefficient loader.
  Assumes dccl_defines.svh is on the include path.
*/
`include "dccl_defines.svh"

package dccl_pkg;
  // ============================================================
  // Decoded page selection, one-hot
  typedef enum logic [5:0] {
    DCCL_PG_NONE = 6'h01,
    DCCL_PG_LO_A = 6'h02,
    DCCL_PG_LO_B = 6'h04,
    DCCL_PG_HI_A = 6'h08,
    DCCL_PG_HI_B = 6'h10,
    DCCL_PG_CTL  = 6'h20
  } dccl_page_t;

  typedef logic [`DCCL_COEF_W-1:0] dccl_coef_t;
endpackage : dccl_pkg

// ---- pkg/dccl_coef_if.sv ----
/*
  Carrier between the loader top and one coefficient memory.
  Assumes a single clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none

`include "dccl_defines.svh"

interface dccl_coef_if;
  logic                       wr_lo;
  logic                       wr_hi;
  logic [`DCCL_RAM_AW-1:0]    waddr;
  logic [`DCCL_DATA_W-1:0]    wdata;
  logic [`DCCL_RAM_AW-1:0]    haddr;
  dccl_pkg::dccl_coef_t       hdata;
  logic [`DCCL_RAM_AW-1:0]    taddr;
  dccl_pkg::dccl_coef_t       tdata;

  modport ctl (output wr_lo, wr_hi, waddr, wdata, haddr, taddr, input hdata, tdata);
  modport ram (input wr_lo, wr_hi, waddr, wdata, haddr, taddr, output hdata, tdata);
endinterface : dccl_coef_if

`default_nettype wire

// ---- logic/dccl_coef_ram.sv ----
/*
  One 32-word by 18-bit coefficient memory with separate writes of the
  two low bits and the sixteen high bits, and two asynchronous read ports.
  Assumes the writer never addresses beyond 31.
*/
`timescale 1ns/1ps
`default_nettype none

`include "dccl_defines.svh"

module dccl_coef_ram (
  // Clock
  input  wire logic i_clk_sys,
  // Memory side
  dccl_coef_if.ram  bus
);
  dccl_pkg::dccl_coef_t mem_q [`DCCL_RAM_DEPTH];

  // ============================================================
  // Part writes; the other part of the word is kept
  always_ff @(posedge i_clk_sys) begin
    if (bus.wr_lo) begin
      mem_q[bus.waddr][`DCCL_LO_W-1:0] <= bus.wdata[`DCCL_LO_W-1:0];
    end
    if (bus.wr_hi) begin
      mem_q[bus.waddr][`DCCL_COEF_W-1:`DCCL_LO_W] <= bus.wdata;
    end
  end

  // ============================================================
  // Read ports for host debug and for the filter
  assign bus.hdata = mem_q[bus.haddr];
  assign bus.tdata = mem_q[bus.taddr];
endmodule : dccl_coef_ram

`default_nettype wire

// ---- logic/dccl_top.sv ----
/*
  Coefficient loader and control registers of one downconverter channel's
  compensating decimation filter, reached through the paged control port.
  Assumes a host on the 6-bit address, 16-bit data port synchronous to
  i_clk_sys; the filter arithmetic sits outside and reads taps here.
*/
// Notes on behaviour
// - Page 0x0480 maps low two bits of memory one onto addresses 0x00-0x1F.
// - Page 0x04A0 maps low two bits of memory two (taps 32-63) there.
// - Page 0x04C0 maps high sixteen bits of memory one there.
// - Page 0x04E0 maps high sixteen bits of memory two there.
// - Page 0x0500 maps the filter control registers onto the control space.
// - Control address 0x00 holds filter mode: CDMA enable and tap counts.
// - Control address 0x01 holds the gain shift settings of both filters.
// - Active compensating taps equal twice the five-bit tap field.
// - Gain bit clear scales by 2^-19, set scales by 2^-18.
// - With read-back set, host can read both coefficient memories.
// - With read-back set, the sample path halts; debug use only.
// - Eighteen-bit coefficients live in two memories of 32 words.
// - In CDMA mode one coefficient set serves both A and B channels.
`timescale 1ns/1ps
`default_nettype none

`include "dccl_defines.svh"

module dccl_top (
  // Clock and reset
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_rst,
  // Control port
  input  wire logic [`DCCL_ADDR_W-1:0]    i_addr,
  input  wire logic [`DCCL_DATA_W-1:0]    i_wdata,
  input  wire logic                       i_wr_stb,
  input  wire logic                       i_rd_stb,
  output logic      [`DCCL_DATA_W-1:0]    o_rdata,
  output logic                            o_rd_valid,
  // Filter tap fetch
  input  wire logic [`DCCL_RAM_AW:0]      i_tap_addr,
  output logic      [`DCCL_COEF_W-1:0]    o_tap_coef,
  // Filter configuration
  output logic                            o_cdma_mode,
  output logic      [`DCCL_RAM_AW+1:0]    o_cfir_taps,
  output logic                            o_cfir_gain_sel,
  output logic      [3:0]                 o_shaping_gain,
  output logic                            o_path_run
);
  dccl_coef_if bank_a ();
  dccl_coef_if bank_b ();

  logic [`DCCL_DATA_W-1:0] page_q, page_d;
  logic [`DCCL_DATA_W-1:0] mode_q, mode_d;
  logic [`DCCL_DATA_W-1:0] gain_q, gain_d;
  logic [`DCCL_DATA_W-1:0] rdata_q, rdata_d;
  logic                    rvalid_q, rvalid_d;
  dccl_pkg::dccl_coef_t    tap_q, tap_d;
  dccl_pkg::dccl_page_t    page_sel;
  logic                    in_win;
  logic                    rdbk;

  // ============================================================
  // Memories
  dccl_coef_ram u_ram_a (
    .i_clk_sys (i_clk_sys),
    .bus       (bank_a)
  );

  dccl_coef_ram u_ram_b (
    .i_clk_sys (i_clk_sys),
    .bus       (bank_b)
  );

  // ============================================================
  // Page decode from the held page register
  always_comb begin
    case (page_q)
      `DCCL_PG_LO0: page_sel = dccl_pkg::DCCL_PG_LO_A;
      `DCCL_PG_LO1: page_sel = dccl_pkg::DCCL_PG_LO_B;
      `DCCL_PG_HI0: page_sel = dccl_pkg::DCCL_PG_HI_A;
      `DCCL_PG_HI1: page_sel = dccl_pkg::DCCL_PG_HI_B;
      `DCCL_PG_CTRL: page_sel = dccl_pkg::DCCL_PG_CTL;
      default: page_sel = dccl_pkg::DCCL_PG_NONE;
    endcase
  end

  assign in_win = (i_addr <= `DCCL_WIN_LAST);
  assign rdbk   = mode_q[`DCCL_MODE_RDBK_BIT];

  // ============================================================
  // Memory write strobes and addresses
  always_comb begin
    bank_a.waddr = i_addr[`DCCL_RAM_AW-1:0];
    bank_b.waddr = i_addr[`DCCL_RAM_AW-1:0];
    bank_a.wdata = i_wdata;
    bank_b.wdata = i_wdata;
    bank_a.wr_lo = i_wr_stb && in_win && (page_sel == dccl_pkg::DCCL_PG_LO_A);
    bank_b.wr_lo = i_wr_stb && in_win && (page_sel == dccl_pkg::DCCL_PG_LO_B);
    bank_a.wr_hi = i_wr_stb && in_win && (page_sel == dccl_pkg::DCCL_PG_HI_A);
    bank_b.wr_hi = i_wr_stb && in_win && (page_sel == dccl_pkg::DCCL_PG_HI_B);
    bank_a.haddr = i_addr[`DCCL_RAM_AW-1:0];
    bank_b.haddr = i_addr[`DCCL_RAM_AW-1:0];
    bank_a.taddr = i_tap_addr[`DCCL_RAM_AW-1:0];
    bank_b.taddr = i_tap_addr[`DCCL_RAM_AW-1:0];
  end

  // ============================================================
  // Register writes
  always_comb begin
    page_d = page_q;
    mode_d = mode_q;
    gain_d = gain_q;
    if (i_wr_stb) begin
      if (i_addr == `DCCL_OFS_PAGE) begin
        page_d = i_wdata;
      end else if (page_sel == dccl_pkg::DCCL_PG_CTL) begin
        if (i_addr == `DCCL_OFS_MODE) begin
          mode_d = i_wdata;
        end else if (i_addr == `DCCL_OFS_GAIN) begin
          gain_d = i_wdata;
        end
      end
    end
  end

  // ============================================================
  // Host read data, one cycle after the strobe
  always_comb begin
    rvalid_d = i_rd_stb;
    rdata_d  = rdata_q;
    if (i_rd_stb) begin
      rdata_d = '0;
      if (i_addr == `DCCL_OFS_PAGE) begin
        rdata_d = page_q;
      end else if (in_win) begin
        case (page_sel)
          dccl_pkg::DCCL_PG_CTL: begin
            if (i_addr == `DCCL_OFS_MODE) begin
              rdata_d = mode_q;
            end else if (i_addr == `DCCL_OFS_GAIN) begin
              rdata_d = gain_q;
            end
          end
          dccl_pkg::DCCL_PG_LO_A: begin
            if (rdbk) begin
              rdata_d = {14'h0000, bank_a.hdata[`DCCL_LO_W-1:0]};
            end
          end
          dccl_pkg::DCCL_PG_LO_B: begin
            if (rdbk) begin
              rdata_d = {14'h0000, bank_b.hdata[`DCCL_LO_W-1:0]};
            end
          end
          dccl_pkg::DCCL_PG_HI_A: begin
            if (rdbk) begin
              rdata_d = bank_a.hdata[`DCCL_COEF_W-1:`DCCL_LO_W];
            end
          end
          dccl_pkg::DCCL_PG_HI_B: begin
            if (rdbk) begin
              rdata_d = bank_b.hdata[`DCCL_COEF_W-1:`DCCL_LO_W];
            end
          end
          default: rdata_d = '0;
        endcase
      end
    end
  end

  // ============================================================
  // Tap fetch for the filter; frozen while read-back halts the path
  always_comb begin
    tap_d = tap_q;
    if (!rdbk) begin
      tap_d = i_tap_addr[`DCCL_RAM_AW] ? bank_b.tdata : bank_a.tdata;
    end
  end

  // ============================================================
  // State registers
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      page_q   <= `DCCL_RST_PAGE;
      mode_q   <= `DCCL_RST_MODE;
      gain_q   <= `DCCL_RST_GAIN;
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
      tap_q    <= '0;
    end else begin
      page_q   <= page_d;
      mode_q   <= mode_d;
      gain_q   <= gain_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      tap_q    <= tap_d;
    end
  end

  // ============================================================
  // Outputs
  assign o_rdata         = rdata_q;
  assign o_rd_valid      = rvalid_q;
  assign o_tap_coef      = tap_q;
  assign o_cdma_mode     = mode_q[`DCCL_MODE_CDMA_BIT];
  assign o_cfir_taps     = {1'b0, mode_q[`DCCL_MODE_TAPS_MSB:`DCCL_MODE_TAPS_LSB], 1'b0};
  assign o_cfir_gain_sel = gain_q[`DCCL_GAIN_CFIR_BIT];
  assign o_shaping_gain  = gain_q[`DCCL_GAIN_SHP_MSB:`DCCL_GAIN_SHP_LSB];
  assign o_path_run      = !rdbk;
endmodule : dccl_top

`default_nettype wire

// ---- bench/dccl_top_sva.sv ----
/* Port checker of the coefficient loader.
   Assumes it is bound onto dccl_top. */
`timescale 1ns/1ps
`default_nettype none
module dccl_chk (
  // Clock and reset
  input wire logic        i_clk_sys,
  input wire logic        i_rst,
  // Control port
  input wire logic [5:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr_stb,
  input wire logic        i_rd_stb,
  input wire logic [15:0] o_rdata,
  input wire logic        o_rd_valid,
  // Filter side
  input wire logic [17:0] o_tap_coef,
  input wire logic        o_cdma_mode,
  input wire logic [6:0]  o_cfir_taps,
  input wire logic        o_cfir_gain_sel,
  input wire logic [3:0]  o_shaping_gain,
  input wire logic        o_path_run
);
  // ==========
  // Page shadow
  logic [15:0] pg_q;
  logic [15:0] pg_d;
  logic        ctl_wr;
  // Next page value
  always_comb begin
    pg_d = (i_wr_stb && i_addr == 6'h21) ? i_wdata : pg_q;
  end
  // Page register
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) pg_q <= 16'h0000;
    else pg_q <= pg_d;
  end
  assign ctl_wr = i_wr_stb && pg_q == 16'h0500;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // ==========
  // Assertions
  a_rd_answer: assert property (
    o_rd_valid == $past(i_rd_stb)) else $error("read answer wrong");
  a_rdata_hold: assert property (
    !i_rd_stb |=> $stable(o_rdata)) else $error("read data moved");
  a_page_held: assert property (
    i_rd_stb && !i_wr_stb && i_addr == 6'h21 |=> o_rdata == $past(pg_q))
    else $error("page not held");
  a_mode_load: assert property (
    ctl_wr && i_addr == 6'h00 |=> o_cdma_mode == $past(i_wdata[15])
    && o_cfir_taps == {1'b0, $past(i_wdata[4:0]), 1'b0}) else $error("mode wrong");
  a_path_halt: assert property (
    ctl_wr && i_addr == 6'h00 |=> o_path_run == !$past(i_wdata[14]))
    else $error("path run wrong");
  a_gain_load: assert property (
    ctl_wr && i_addr == 6'h01 |=> o_cfir_gain_sel == $past(i_wdata[8])
    && o_shaping_gain == $past(i_wdata[15:12])) else $error("gain wrong");
  a_tap_frozen: assert property (
    !o_path_run ##1 !o_path_run |-> $stable(o_tap_coef)) else $error("tap moved");
  a_unmapped_zero: assert property (
    i_rd_stb && i_addr > 6'h21 |=> o_rdata == 16'h0000) else $error("unmapped read");
endmodule : dccl_chk
bind dccl_top dccl_chk dccl_chk_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
  .o_rdata(o_rdata), .o_rd_valid(o_rd_valid), .o_tap_coef(o_tap_coef),
  .o_cdma_mode(o_cdma_mode), .o_cfir_taps(o_cfir_taps),
  .o_cfir_gain_sel(o_cfir_gain_sel), .o_shaping_gain(o_shaping_gain),
  .o_path_run(o_path_run));
`default_nettype wire

// ---- bench/dccl_host.sv ----
/* Host processor model on the paged control port.
   Assumes the bench calls its tasks after reset. */
`timescale 1ns/1ps
`default_nettype none
module dccl_host (
  // Clock
  input  wire logic        i_clk_sys,
  // Control port
  output logic      [5:0]  o_addr,
  output logic      [15:0] o_wdata,
  output logic             o_wr_stb,
  output logic             o_rd_stb,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_rd_valid
);
  // Idle bus at time zero
  initial begin
    o_addr   = 6'h3F;
    o_wdata  = 16'h0000;
    o_wr_stb = 1'b0;
    o_rd_stb = 1'b0;
  end
  // One write; released lines show inverted values
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge i_clk_sys);
    o_addr   = a;
    o_wdata  = d;
    o_wr_stb = 1'b1;
    @(negedge i_clk_sys);
    o_wr_stb = 1'b0;
    o_addr   = ~a;
    o_wdata  = ~d;
  endtask : wr
  // One read; answer taken in the cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(negedge i_clk_sys);
    o_addr   = a;
    o_rd_stb = 1'b1;
    @(negedge i_clk_sys);
    o_rd_stb = 1'b0;
    o_addr   = ~a;
    d        = i_rd_valid ? i_rdata : 16'hXXXX;
  endtask : rd
  // One coefficient: high word, then low two bits, same word address
  task automatic coef(input logic m, input logic [5:0] w, input logic [17:0] c);
    wr(6'h21, m ? 16'h04E0 : 16'h04C0);
    wr(w, c[17:2]);
    wr(6'h21, m ? 16'h04A0 : 16'h0480);
    wr(w, {14'h0000, c[1:0]});
  endtask : coef
endmodule : dccl_host
`default_nettype wire

// ---- bench/dccl_top_tb.sv ----
/* Self-checking bench of the coefficient loader.
   Assumes the host model and bound checker. */
`timescale 1ns/1ps
`default_nettype none
module dccl_top_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [5:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        rvalid;
  logic [5:0]  tap_addr = 6'h00;
  logic [17:0] tap_coef;
  logic        cdma;
  logic [6:0]  taps;
  logic        gsel;
  logic [3:0]  sgain;
  logic        run;
  logic [17:0] cf [4] = '{18'h3FFF3, 18'h1FFFF, 18'h1FFFF, 18'h3FFF3};
  int          bad_count = 0;
  int          check_count = 0;
  always #2 clk = ~clk;
  dccl_top dccl_top_i (.i_clk_sys(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr_stb(wr), .i_rd_stb(rd), .o_rdata(rdata), .o_rd_valid(rvalid),
    .i_tap_addr(tap_addr), .o_tap_coef(tap_coef), .o_cdma_mode(cdma),
    .o_cfir_taps(taps), .o_cfir_gain_sel(gsel), .o_shaping_gain(sgain), .o_path_run(run));
  dccl_host dccl_host_i (.i_clk_sys(clk), .o_addr(addr), .o_wdata(wdata), .o_wr_stb(wr),
    .o_rd_stb(rd), .i_rdata(rdata), .i_rd_valid(rvalid));
  // Compare and count
  task automatic chk(input string n, input logic [17:0] s, input logic [17:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  // Verdict and end of run
  task automatic complete_run;
    if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  // Read one address and compare
  task automatic rc(input logic [5:0] a, input logic [15:0] e);
    logic [15:0] d;
    dccl_host_i.rd(a, d);
    chk("read", {2'b00, d}, {2'b00, e});
  endtask : rc
  // Fetch one tap and compare
  task automatic tap(input logic [5:0] a, input logic [17:0] e);
    @(negedge clk);
    tap_addr = a;
    @(negedge clk);
    chk("tap", tap_coef, e);
  endtask : tap
  // Main sequence
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    rc(6'h21, 16'h0000);
    chk("run", {17'h00000, run}, 18'h00001);
    for (int k = 0; k < 4; k++) dccl_host_i.coef(k[1], k[0] ? 6'h1C : 6'h00, cf[k]);
    dccl_host_i.coef(1'b0, 6'h1D, 18'h00000);
    for (int k = 0; k < 4; k++) tap({k[1], k[0] ? 5'h1C : 5'h00}, cf[k]);
    tap(6'h1D, 18'h00000);
    dccl_host_i.wr(6'h21, 16'h0400);
    dccl_host_i.wr(6'h00, 16'h1234);
    tap(6'h00, cf[0]);
    rc(6'h00, 16'h0000);
    dccl_host_i.wr(6'h21, 16'h0500);
    dccl_host_i.wr(6'h00, 16'h8EE0);
    dccl_host_i.wr(6'h01, 16'h2000);
    rc(6'h00, 16'h8EE0);
    chk("cdma", {17'h00000, cdma}, 18'h00001);
    chk("gain", {13'h0000, gsel, sgain}, 18'h00002);
    dccl_host_i.wr(6'h00, 16'h801D);
    chk("taps", {11'h000, taps}, 18'h0003A);
    dccl_host_i.wr(6'h01, 16'h2100);
    chk("gsel", {17'h00000, gsel}, 18'h00001);
    rc(6'h05, 16'h0000);
    rc(6'h3F, 16'h0000);
    dccl_host_i.wr(6'h21, 16'h04C0);
    rc(6'h1C, 16'h0000);
    dccl_host_i.wr(6'h21, 16'h0500);
    dccl_host_i.wr(6'h00, 16'hC01D);
    chk("halt", {17'h00000, run}, 18'h00000);
    // A new tap address while halted must not reach the filter
    tap(6'h20, cf[0]);
    dccl_host_i.wr(6'h21, 16'h04C0);
    rc(6'h1C, 16'h7FFF);
    dccl_host_i.wr(6'h21, 16'h04A0);
    rc(6'h00, 16'h0003);
    dccl_host_i.wr(6'h21, 16'h0500);
    dccl_host_i.wr(6'h00, 16'h801D);
    chk("resume", {17'h00000, run}, 18'h00001);
    tap(6'h20, cf[2]);
    complete_run;
  end
  // Watchdog
  initial begin
    #20000;
    bad_count++;
    complete_run;
  end
endmodule : dccl_top_tb
`default_nettype wire
